// >>> por_seq_defs.vh
// Constants for the power-on reset sequencer: timing, counter width.
// Assumes a 10 MHz free-running timebase clock on clk_i.
// Functional notes
// [R1] Start power-up only once supply is above the startup threshold.
// [R2] Supply below shutdown threshold shuts down every unit, audio path included.
// [R3] Supply above startup for over 5 ms enables the charge pump.
// [R4] After further 5 ms settle, pulse internal reset to enable the core.
// [R5] Sequence start disables audio and asynchronously defaults all config registers.
// [R6] Order: regulators, charge pump, core clock feed, then ROM application start.
// [R7] After a supply dip, rerun the full sequence once supply requalifies.
// [R8] Delay counters run on a free timebase; clear on supply loss.
`ifndef POR_SEQ_DEFS_VH
`define POR_SEQ_DEFS_VH
// Counter width holds the longer of the two waits
`define CNT_W 17
// 50001 cycles of the 100 ns timebase: strictly more than 5 ms of good supply
`define STAB_CYCLES 17'h0C351
// 50000 cycles: 5 ms for the charge pump to settle
`define SETTLE_CYCLES 17'h0C350
// Core reset low time in cycles before release
`define RST_PULSE_CYCLES 3'h4
`endif

// >>> delay_timer.v
// Cycle counter that flags when a loaded count has elapsed.
// Assumes a free-running clock; restart clears and reloads.
`timescale 1ns/1ps
`include "por_seq_defs.vh"
module delay_timer
(
	input wire clk_i,
	input wire rst_b_i,
	input wire run_i,
	input wire [`CNT_W-1:0] limit_i,
	output wire done_o
);
	reg [`CNT_W-1:0] count_reg;
	reg [`CNT_W-1:0] count_next;

	always @*
	begin
		count_next = count_reg;
		if (!run_i)
			count_next = {`CNT_W{1'b0}}; // R8
		else if (count_reg < limit_i)
			count_next = count_reg + {{(`CNT_W-1){1'b0}}, 1'b1};
	end

	always @(posedge clk_i)
	begin
		if (!rst_b_i)
			count_reg <= {`CNT_W{1'b0}};
		else
			count_reg <= count_next;
	end

	// Registered count against limit decides done, so the caller may gate run with done without a loop
	assign done_o = (count_reg >= limit_i);
endmodule

// >>> power_on_reset_sequencer.v
// Power-on reset sequencer and brown-out supervisor.
// Assumes supply comparator outputs are synchronous to the free-running clk_i.
// Assumes consumers of config_rst_b_o apply it as an asynchronous reset level.
`timescale 1ns/1ps
`include "por_seq_defs.vh"
module power_on_reset_sequencer
(
	input wire clk_i,
	input wire rst_b_i,
	input wire supply_above_startup_i,
	input wire supply_below_shutdown_i,
	output reg regulator_en_o,
	output reg charge_pump_en_o,
	output reg core_rst_b_o,
	output reg config_rst_b_o,
	output reg core_clock_feed_en_o,
	output reg rom_start_o,
	output reg audio_en_o,
	output reg units_en_o
);
	// State codes; an illegal code falls to the default branch and back to off
	localparam [2:0] ST_OFF = 3'h0;
	localparam [2:0] ST_QUAL = 3'h1;
	localparam [2:0] ST_PUMP = 3'h2;
	localparam [2:0] ST_RESET = 3'h3;
	localparam [2:0] ST_CLOCK = 3'h4;
	localparam [2:0] ST_RUN = 3'h5;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [2:0] pulse_reg;
	reg [2:0] pulse_next;
	reg [`CNT_W-1:0] limit;
	reg timer_run;
	reg shutdown_req;
	// Stage levels decoded from the state about to be entered
	reg reg_stage_next;
	reg pump_stage_next;
	reg core_stage_next;
	reg run_stage_next;
	wire timer_done;

	delay_timer delay_timer_inst
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.run_i(timer_run),
		.limit_i(limit),
		.done_o(timer_done)
	);

	// Brown-out wins over every other transition
	always @*
	begin
		shutdown_req = supply_below_shutdown_i; // R2
	end

	// Each wait is timed from its own start: the timer is held clear outside a wait,
	// so the next wait never inherits a count from the one before
	always @*
	begin
		timer_run = 1'b0;
		limit = `STAB_CYCLES;
		case (state_reg)
			ST_QUAL:
			begin
				timer_run = supply_above_startup_i && !supply_below_shutdown_i; // R3
			end
			ST_PUMP:
			begin
				timer_run = !supply_below_shutdown_i; // R8
				limit = `SETTLE_CYCLES; // R4
			end
			default:
			begin
				timer_run = 1'b0;
			end
		endcase
		// Leaving a wait clears the count on that same edge
		if (state_next != state_reg)
			timer_run = 1'b0; // R8
	end

	// Next state
	always @*
	begin
		state_next = state_reg;
		if (shutdown_req)
			state_next = ST_OFF; // R2 R8
		else
		begin
			case (state_reg)
				ST_OFF:
				begin
					if (supply_above_startup_i)
						state_next = ST_QUAL; // R1 R7
				end
				ST_QUAL:
				begin
					// Supply must stay above startup the whole wait, else start over
					if (!supply_above_startup_i)
						state_next = ST_OFF; // R3
					else if (timer_done)
						state_next = ST_PUMP; // R3
				end
				ST_PUMP:
				begin
					if (timer_done)
						state_next = ST_RESET; // R4
				end
				ST_RESET:
				begin
					if (pulse_reg == `RST_PULSE_CYCLES - 3'h1)
						state_next = ST_CLOCK; // R4
				end
				ST_CLOCK:
				begin
					state_next = ST_RUN; // R6
				end
				ST_RUN:
				begin
					// Stays here until a brown-out; the shutdown branch takes it out
					state_next = ST_RUN;
				end
				default:
				begin
					state_next = ST_OFF;
				end
			endcase
		end
	end

	// Core reset low time: counts only in the reset state, cleared elsewhere
	always @*
	begin
		pulse_next = 3'h0;
		if (state_reg == ST_RESET && pulse_reg != `RST_PULSE_CYCLES - 3'h1)
			pulse_next = pulse_reg + 3'h1; // R4
		else if (state_reg == ST_RESET)
			pulse_next = pulse_reg;
	end

	// State and pulse counter share one synchronous reset
	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			state_reg <= ST_OFF;
			pulse_reg <= 3'h0;
		end
		else
		begin
			state_reg <= state_next;
			pulse_reg <= pulse_next;
		end
	end

	// Decoded from the next state so the pins move on the same edge as the state
	always @*
	begin
		reg_stage_next = 1'b0;
		pump_stage_next = 1'b0;
		core_stage_next = 1'b0;
		run_stage_next = 1'b0;
		case (state_next)
			ST_OFF:
			begin
				reg_stage_next = 1'b0; // R2
			end
			ST_QUAL:
			begin
				reg_stage_next = 1'b1; // R6
			end
			ST_PUMP, ST_RESET:
			begin
				reg_stage_next = 1'b1;
				pump_stage_next = 1'b1; // R3 R6
			end
			ST_CLOCK:
			begin
				reg_stage_next = 1'b1;
				pump_stage_next = 1'b1;
				core_stage_next = 1'b1; // R4 R6
			end
			ST_RUN:
			begin
				reg_stage_next = 1'b1;
				pump_stage_next = 1'b1;
				core_stage_next = 1'b1;
				run_stage_next = 1'b1; // R6
			end
			default:
			begin
				reg_stage_next = 1'b0;
			end
		endcase
	end

	// Registered so the pins never glitch while the state decode settles
	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			regulator_en_o <= 1'b0;
			charge_pump_en_o <= 1'b0;
			core_rst_b_o <= 1'b0;
			config_rst_b_o <= 1'b0;
			core_clock_feed_en_o <= 1'b0;
			rom_start_o <= 1'b0;
			audio_en_o <= 1'b0;
			units_en_o <= 1'b0;
		end
		else
		begin
			regulator_en_o <= reg_stage_next; // R6
			charge_pump_en_o <= pump_stage_next; // R3
			core_rst_b_o <= core_stage_next; // R4
			// Consumers apply this level asynchronously; it is low until the core reset is released
			config_rst_b_o <= core_stage_next; // R5
			core_clock_feed_en_o <= core_stage_next; // R6
			rom_start_o <= run_stage_next; // R6
			// Audio stays off until the ROM application runs, and drops with any shutdown
			audio_en_o <= run_stage_next; // R5 R2
			units_en_o <= run_stage_next; // R2
		end
	end
endmodule

// >>> supply_model.sv
// Supply comparators: millivolt level in, startup and shutdown flags out.
// Assumes the bench moves the level away from clock edges.
`timescale 1ns/1ps
module supply_model
(
	input wire clk_i,
	input wire [11:0] mv_i,
	output logic above_o,
	output logic below_o
);
	initial
	begin
		above_o = 1'b0;
		below_o = 1'b1;
	end
	always @(posedge clk_i)
	begin
		above_o <= mv_i > 12'h672;
		below_o <= mv_i < 12'h640;
	end
endmodule

// >>> seq_chk.sv
// Checker for the reset sequencer.
// Assumes it is bound to the sequencer top.
`timescale 1ns/1ps
module seq_chk
(
	input wire clk_i,
	input wire rst_b_i,
	input wire supply_above_startup_i,
	input wire supply_below_shutdown_i,
	input wire regulator_en_o,
	input wire charge_pump_en_o,
	input wire core_rst_b_o,
	input wire config_rst_b_o,
	input wire core_clock_feed_en_o,
	input wire rom_start_o,
	input wire audio_en_o,
	input wire units_en_o
);
	int cnt;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence qual_s;
		regulator_en_o && !charge_pump_en_o;
	endsequence
	// Cycles since the regulator or charge pump stage last rose, so each wait can be sized
	always @(posedge clk_i)
		cnt <= ($rose(regulator_en_o) || $rose(charge_pump_en_o)) ? 0 : cnt + 1;
	AST_SHUT: assert property (supply_below_shutdown_i |=> !units_en_o && !audio_en_o)
		else $error("units or audio still on after a brown-out");
	AST_START: assert property (!regulator_en_o && !supply_above_startup_i |=> !regulator_en_o)
		else $error("regulators enabled without a good supply");
	AST_PUMP: assert property ($rose(charge_pump_en_o) |-> cnt > 50000)
		else $error("charge pump enabled too early");
	AST_SETTLE: assert property ($rose(core_rst_b_o) |-> cnt >= 50000)
		else $error("core reset released before the pump settled");
	AST_ORDER: assert property (rom_start_o |-> core_clock_feed_en_o && charge_pump_en_o)
		else $error("ROM start ahead of clock feed or pump");
	AST_CFG: assert property ($rose(regulator_en_o) |-> !config_rst_b_o && !audio_en_o)
		else $error("config reset or audio not held at sequence start");
	AST_DROP: assert property ((qual_s ##0 !supply_above_startup_i) |=> !regulator_en_o)
		else $error("qualification not abandoned on supply drop");
	AST_RERUN: assert property (!regulator_en_o |=> !charge_pump_en_o)
		else $error("charge pump on without the regulator stage");
endmodule
bind power_on_reset_sequencer seq_chk seq_chk_inst
(
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.supply_above_startup_i(supply_above_startup_i),
	.supply_below_shutdown_i(supply_below_shutdown_i),
	.regulator_en_o(regulator_en_o),
	.charge_pump_en_o(charge_pump_en_o),
	.core_rst_b_o(core_rst_b_o),
	.config_rst_b_o(config_rst_b_o),
	.core_clock_feed_en_o(core_clock_feed_en_o),
	.rom_start_o(rom_start_o),
	.audio_en_o(audio_en_o),
	.units_en_o(units_en_o)
);

// >>> power_on_reset_sequencer_tb.sv
// Bench for the reset sequencer: drop, full run, dip.
// Assumes the full 5 ms counts of the design header.
`timescale 1ns/1ps
module power_on_reset_sequencer_tb;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [11:0] mv = 12'h000;
	wire supply_above_startup_i, supply_below_shutdown_i, regulator_en_o, charge_pump_en_o, core_rst_b_o;
	wire config_rst_b_o, core_clock_feed_en_o, rom_start_o, audio_en_o, units_en_o;
	wire [7:0] o = {regulator_en_o, charge_pump_en_o, core_rst_b_o, config_rst_b_o,
		core_clock_feed_en_o, rom_start_o, audio_en_o, units_en_o};
	int err_count = 0;
	int tests_run = 0;
	always #50 clk_i = ~clk_i;
	supply_model supply_model_inst (.clk_i(clk_i), .mv_i(mv), .above_o(supply_above_startup_i),
		.below_o(supply_below_shutdown_i));
	power_on_reset_sequencer power_on_reset_sequencer_inst
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.supply_above_startup_i(supply_above_startup_i),
		.supply_below_shutdown_i(supply_below_shutdown_i),
		.regulator_en_o(regulator_en_o),
		.charge_pump_en_o(charge_pump_en_o),
		.core_rst_b_o(core_rst_b_o),
		.config_rst_b_o(config_rst_b_o),
		.core_clock_feed_en_o(core_clock_feed_en_o),
		.rom_start_o(rom_start_o),
		.audio_en_o(audio_en_o),
		.units_en_o(units_en_o)
	);
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %0t %h %h", $time, g, e);
		end
	endtask
	task t_drop;
		mv = 12'h6A4;
		step(100);
		chk(o, 8'h80);
		mv = 12'h654;
		step(3);
		chk(o, 8'h00);
		step(100);
		chk(o, 8'h00);
		$display("drop done");
	endtask
	task t_full;
		mv = 12'h6A4;
		step(50000);
		chk(o, 8'h80);
		step(10);
		chk(o, 8'hC0);
		step(49990);
		chk(o, 8'hC0);
		step(20);
		chk(o, 8'hFF);
		$display("full done");
	endtask
	task t_dip;
		mv = 12'h5DC;
		step(3);
		chk(o, 8'h00);
		mv = 12'h6A4;
		step(3);
		chk(o, 8'h80);
		$display("dip done");
	endtask
	task give_verdict;
		$display("ran %0d bad %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#12000000;
		err_count++;
		give_verdict;
	end
	initial
	begin
		step(2);
		rst_b_i = 1'b1;
		t_drop;
		t_full;
		t_dip;
		give_verdict;
	end
endmodule
